/* design/dbsp_pkg.sv */
// shared constants and types for the dram byte strobe and page burst block
package dbsp_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_DRAM_CONTROL_REG = 8'h00;
	localparam logic [7:0] OFS_WAIT_CONTROL_REG = 8'h04;
	localparam logic [7:0] OFS_STATUS           = 8'h08;

	// ------------------------------------------------------------
	// dram_control_reg fields
	// ------------------------------------------------------------
	localparam int BIT_DUAL_STROBE_STYLE    = 0;
	localparam int BIT_PAGE_BURST_ENABLE    = 1;
	localparam int BIT_ROW_STROBE_HOLD      = 2;
	localparam int BIT_COLUMN_STROBE_DUTY   = 3;
	localparam int BIT_PRECHARGE_LENGTH     = 4;
	localparam int CTRL_W                   = 5;
	localparam logic [4:0] CTRL_RESET       = 5'h00;

	// ------------------------------------------------------------
	// wait control fields (one pitch bit per direction and master kind)
	// ------------------------------------------------------------
	localparam int BIT_AREA1_READ_LONG      = 0;
	localparam int BIT_AREA1_WRITE_LONG     = 1;
	localparam int BIT_AREA1_DMA_READ_LONG  = 2;
	localparam int BIT_AREA1_DMA_WRITE_LONG = 3;
	localparam int PITCH_W                  = 4;
	localparam logic [3:0] PITCH_RESET      = 4'h0;

	// ------------------------------------------------------------
	// status fields
	// ------------------------------------------------------------
	localparam int BIT_ROW_OPEN     = 0;
	localparam int POS_STATE        = 8;
	localparam int POS_OPEN_ROW     = 16;

	// ------------------------------------------------------------
	// timing: precharge states per length select
	// ------------------------------------------------------------
	localparam logic PRECHARGE_EXTRA_SHORT = 1'b0;
	localparam logic PRECHARGE_EXTRA_LONG  = 1'b1;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_PRECHG  = 7'h02,
		ST_ROW     = 7'h04,
		ST_SILENT  = 7'h08,
		ST_COL1    = 7'h10,
		ST_COL2    = 7'h20,
		ST_REFRESH = 7'h40
	} dbsp_state_t;

endpackage

/* design/dbsp_lane_decode.sv */
// byte lane decode of column and write strobes
`timescale 1ns/1ps
module dbsp_lane_decode (
	// strobe timing
	input  wire logic col_active,
	input  wire logic write,
	// access shape
	input  wire logic bus8,
	input  wire logic dual_strobe_style_select,
	input  wire logic lane_hi,
	input  wire logic lane_lo,
	// active high strobes
	output logic      cas_hi,
	output logic      cas_lo,
	output logic      wr_hi,
	output logic      wr_lo
);
	always_comb begin
		cas_hi = 1'b0;
		cas_lo = 1'b0;
		wr_hi  = 1'b0;
		wr_lo  = 1'b0;
		if (col_active) begin
			if (bus8) begin
				cas_lo = 1'b1; // RULE3
				wr_lo  = write; // RULE3
			end else if (!dual_strobe_style_select) begin
				cas_hi = lane_hi; // RULE1
				cas_lo = lane_lo; // RULE1
				wr_lo  = write; // RULE1
			end else begin
				cas_lo = 1'b1; // RULE2
				wr_hi  = write & lane_hi; // RULE2
				wr_lo  = write & lane_lo; // RULE2
			end
		end
	end
endmodule

/* design/dbsp_top.sv */
// dram byte strobe and page burst sequencer with ahb-lite registers
// Contract
// (RULE1) 16-bit, dual column strobes: both column, low write
// (RULE2) 16-bit, dual write: low column, both writes
// (RULE3) 8-bit space: low column and low write only
// (RULE4) burst enable: same row uses page access
// (RULE5) four pitch bits select short or long
// (RULE6) short pitch: one column state, no wait
// (RULE7) short pitch write after write: one silent
// (RULE8) short pitch write after read: one silent
// (RULE9) single-address dma write short pitch: silent always
// (RULE10) short pitch column high duty 50 or 35
// (RULE11) long pitch: two column states per access
// (RULE12) long pitch: repeat second state while wait low
// (RULE13) hold bit selects hold or release row strobe
// (RULE14) bursting survives change of bus master
// (RULE15) hold mode: row low across other areas
// (RULE16) refresh always returns row strobe high
// (RULE17) software programs periodic refresh in hold mode
// (RULE18) release mode: row high on other area
// (RULE19) precharge one or two states per select
// (RULE20) long pitch samples wait before second column
// (RULE21) burst miss: precharge then full row access
`timescale 1ns/1ps
module dbsp_top
	import dbsp_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// access request from the bus state controller
	input  wire logic              acc_req,
	input  wire logic [ADDR_W-1:0] acc_row,
	input  wire logic [ADDR_W-1:0] acc_col,
	input  wire logic              acc_write,
	input  wire logic              acc_dma,
	input  wire logic              acc_dma_single,
	input  wire logic              acc_bus8,
	input  wire logic              acc_lane_hi,
	input  wire logic              acc_lane_lo,
	output logic                   acc_done,
	// other areas and refresh
	input  wire logic              other_area_active,
	input  wire logic              refresh_req,
	output logic                   refresh_done,
	// dram pins
	input  wire logic              wait_n,
	output logic                   row_strobe_n,
	output logic                   column_strobe_upper_byte_n,
	output logic                   column_strobe_lower_byte_n,
	output logic                   write_strobe_upper_byte_n,
	output logic                   write_strobe_lower_byte_n,
	output logic [ADDR_W-1:0]      dram_addr,
	output logic                   column_strobe_short_duty
);

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [CTRL_W-1:0]  dram_control_reg, next_dram_control_reg;
	logic [PITCH_W-1:0] wait_control_reg, next_wait_control_reg;
	logic               wr_pend, next_wr_pend;
	logic [7:0]         wr_ofs, next_wr_ofs;
	logic [31:0]        next_hrdata;
	logic [31:0]        status_word;
	logic               addr_phase;

	dbsp_state_t        state, next_state;
	logic               row_open, next_row_open;
	logic [ADDR_W-1:0]  open_row, next_open_row;

	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addr_phase = hsel & hready & htrans[1];

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[BIT_ROW_OPEN] = row_open;
		status_word[POS_STATE +: 7] = state;
		status_word[POS_OPEN_ROW +: ADDR_W] = open_row;
	end

	always_comb begin
		next_dram_control_reg = dram_control_reg;
		next_wait_control_reg = wait_control_reg;
		next_wr_pend = addr_phase & hwrite;
		next_wr_ofs  = haddr[7:0];
		next_hrdata  = hrdata;
		if (wr_pend) begin
			unique case (wr_ofs)
				OFS_DRAM_CONTROL_REG:
					next_dram_control_reg = hwdata[CTRL_W-1:0];
				OFS_WAIT_CONTROL_REG:
					next_wait_control_reg = hwdata[PITCH_W-1:0];
				default: ;
			endcase
		end
		if (addr_phase && !hwrite) begin
			unique case (haddr[7:0])
				OFS_DRAM_CONTROL_REG:
					next_hrdata = {27'h0, dram_control_reg};
				OFS_WAIT_CONTROL_REG:
					next_hrdata = {28'h0000000, wait_control_reg};
				OFS_STATUS:
					next_hrdata = status_word;
				default:
					next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dram_control_reg <= CTRL_RESET;
			wait_control_reg <= PITCH_RESET;
			wr_pend          <= 1'b0;
			wr_ofs           <= 8'h00;
			hrdata           <= 32'h0000_0000;
		end else begin
			dram_control_reg <= next_dram_control_reg;
			wait_control_reg <= next_wait_control_reg;
			wr_pend          <= next_wr_pend;
			wr_ofs           <= next_wr_ofs;
			hrdata           <= next_hrdata;
		end
	end

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	logic burst_en, hold_sel, long_pitch, row_hit, need_silent;
	logic pre_cnt, next_pre_cnt;
	logic col_final, next_col_final;
	logic next_acc_done, next_refresh_done;
	logic next_row_strobe_n;
	logic [ADDR_W-1:0] next_dram_addr;

	assign burst_en = dram_control_reg[BIT_PAGE_BURST_ENABLE];
	assign hold_sel = dram_control_reg[BIT_ROW_STROBE_HOLD]; // RULE13

	// pitch per direction and master kind
	always_comb begin
		if (acc_dma)
			long_pitch = acc_write
				? wait_control_reg[BIT_AREA1_DMA_WRITE_LONG]
				: wait_control_reg[BIT_AREA1_DMA_READ_LONG]; // RULE5
		else
			long_pitch = acc_write
				? wait_control_reg[BIT_AREA1_WRITE_LONG]
				: wait_control_reg[BIT_AREA1_READ_LONG]; // RULE5
	end

	// the open row is tracked regardless of master identity
	assign row_hit = burst_en & row_open & (acc_row == open_row); // RULE4 RULE14
	assign need_silent = ~long_pitch & acc_write
		& (row_hit | acc_dma_single); // RULE7 RULE8 RULE9

	always_comb begin
		next_state        = state;
		next_row_open     = row_open;
		next_open_row     = open_row;
		next_pre_cnt      = pre_cnt;
		next_col_final    = col_final;
		next_acc_done     = 1'b0;
		next_refresh_done = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (refresh_req) begin
					next_state    = ST_REFRESH;
					next_row_open = 1'b0; // RULE16
				end else if (acc_req) begin
					if (row_hit) begin
						next_state = need_silent ? ST_SILENT : ST_COL1; // RULE4
					end else begin
						next_state    = ST_PRECHG; // RULE21
						next_row_open = 1'b0;
						next_pre_cnt  =
							dram_control_reg[BIT_PRECHARGE_LENGTH]
							? PRECHARGE_EXTRA_LONG
							: PRECHARGE_EXTRA_SHORT; // RULE19
					end
				end else if (other_area_active && !hold_sel) begin
					next_row_open = 1'b0; // RULE18
				end
			end
			ST_PRECHG: begin
				if (pre_cnt == 1'b0)
					next_state = ST_ROW; // RULE19
				else
					next_pre_cnt = 1'b0;
			end
			ST_ROW: begin
				next_row_open = 1'b1;
				next_open_row = acc_row;
				next_state    = need_silent ? ST_SILENT : ST_COL1; // RULE9
			end
			ST_SILENT: begin
				next_state = ST_COL1; // RULE7 RULE8
			end
			ST_COL1: begin
				if (long_pitch) begin
					next_state     = ST_COL2; // RULE11
					next_col_final = wait_n; // RULE20
				end else begin
					next_state    = ST_IDLE; // RULE6
					next_acc_done = 1'b1;
					next_row_open = burst_en; // RULE4
				end
			end
			ST_COL2: begin
				if (col_final) begin
					next_state    = ST_IDLE; // RULE11
					next_acc_done = 1'b1;
					next_row_open = burst_en; // RULE4
				end else begin
					next_col_final = wait_n; // RULE12 RULE20
				end
			end
			ST_REFRESH: begin
				next_state        = ST_IDLE;
				next_refresh_done = 1'b1; // RULE16
			end
			default: begin
				next_state    = ST_IDLE;
				next_row_open = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// pin shaping, registered from the next state
	// ------------------------------------------------------------
	logic col_next, col_extra;
	logic cas_hi, cas_lo, wr_hi, wr_lo;

	// wait_n is sampled on the edge that closes the first long
	// column state; a low level repeats the second state as a wait
	assign col_extra = (state == ST_COL2) & ~col_final; // RULE12
	assign col_next  = (next_state == ST_COL1)
		| (next_state == ST_COL2) | col_extra;

	dbsp_lane_decode u_lane (
		.col_active               (col_next),
		.write                    (acc_write),
		.bus8                     (acc_bus8),
		.dual_strobe_style_select (dram_control_reg[BIT_DUAL_STROBE_STYLE]),
		.lane_hi                  (acc_lane_hi),
		.lane_lo                  (acc_lane_lo),
		.cas_hi                   (cas_hi),
		.cas_lo                   (cas_lo),
		.wr_hi                    (wr_hi),
		.wr_lo                    (wr_lo)
	);

	always_comb begin
		// row low while a row is open or being opened
		next_row_strobe_n = ~(next_row_open
			| (next_state == ST_ROW)
			| (next_state == ST_SILENT)
			| col_next); // RULE15 RULE18
		if ((next_state == ST_PRECHG) || (next_state == ST_REFRESH))
			next_row_strobe_n = 1'b1; // RULE16 RULE19
		if (col_next)
			next_dram_addr = acc_col;
		else
			next_dram_addr = acc_row;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state                      <= ST_IDLE;
			row_open                   <= 1'b0;
			open_row                   <= '0;
			pre_cnt                    <= 1'b0;
			col_final                  <= 1'b0;
			acc_done                   <= 1'b0;
			refresh_done               <= 1'b0;
			row_strobe_n               <= 1'b1;
			column_strobe_upper_byte_n <= 1'b1;
			column_strobe_lower_byte_n <= 1'b1;
			write_strobe_upper_byte_n  <= 1'b1;
			write_strobe_lower_byte_n  <= 1'b1;
			dram_addr                  <= '0;
			column_strobe_short_duty   <= 1'b0;
		end else begin
			state                      <= next_state;
			row_open                   <= next_row_open;
			open_row                   <= next_open_row;
			pre_cnt                    <= next_pre_cnt;
			col_final                  <= next_col_final;
			acc_done                   <= next_acc_done;
			refresh_done               <= next_refresh_done;
			row_strobe_n               <= next_row_strobe_n;
			column_strobe_upper_byte_n <= ~cas_hi;
			column_strobe_lower_byte_n <= ~cas_lo;
			write_strobe_upper_byte_n  <= ~wr_hi;
			write_strobe_lower_byte_n  <= ~wr_lo;
			dram_addr                  <= next_dram_addr;
			// pad cell shortens column high phase to 35 percent
			column_strobe_short_duty   <= col_next & ~long_pitch
				& dram_control_reg[BIT_COLUMN_STROBE_DUTY]; // RULE10
		end
	end

endmodule

/* bench/dbsp_chk.sv */
// port assertions for the dram strobe sequencer
`timescale 1ns/1ps
module dbsp_chk
	import dbsp_pkg::*;
(
	// clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// access port
	input wire logic              acc_req,
	input wire logic              acc_write,
	input wire logic              acc_bus8,
	input wire logic              acc_done,
	input wire logic              refresh_done,
	input wire logic [ADDR_W-1:0] acc_row,
	input wire logic [ADDR_W-1:0] acc_col,
	// dram pins
	input wire logic [ADDR_W-1:0] dram_addr,
	input wire logic              row_strobe_n,
	input wire logic              column_strobe_upper_byte_n,
	input wire logic              column_strobe_lower_byte_n,
	input wire logic              write_strobe_upper_byte_n,
	input wire logic              write_strobe_lower_byte_n
);
	// --------
	// properties
	// --------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_done; acc_done |=> !acc_done; endproperty
	a_done: assert property (p_done) else $error("done too long");
	property p_rfsh; refresh_done |-> $past(row_strobe_n); endproperty
	a_rfsh: assert property (p_rfsh) else $error("row low at refresh");
	property p_row;
		$fell(row_strobe_n) |-> acc_req && dram_addr == acc_row;
	endproperty
	a_row: assert property (p_row) else $error("bad row address");
	property p_col;
		$fell(column_strobe_lower_byte_n) && acc_req |-> dram_addr == acc_col;
	endproperty
	a_col: assert property (p_col) else $error("bad column address");
	property p_b8;
		acc_req && acc_bus8 |->
			column_strobe_upper_byte_n && write_strobe_upper_byte_n;
	endproperty
	a_b8: assert property (p_b8) else $error("upper strobe in 8-bit");
	property p_wr; !write_strobe_lower_byte_n |-> acc_req && acc_write; endproperty
	a_wr: assert property (p_wr) else $error("write strobe on read");
	property p_wh;
		!write_strobe_upper_byte_n |-> acc_write && !acc_bus8;
	endproperty
	a_wh: assert property (p_wh) else $error("bad upper write");
	property p_ch; !column_strobe_upper_byte_n && acc_req |-> !acc_bus8; endproperty
	a_ch: assert property (p_ch) else $error("bad upper column");
	c_done: cover property (acc_done);
	c_rfsh: cover property (refresh_done);
	c_row: cover property ($fell(row_strobe_n));
endmodule

bind dbsp_top dbsp_chk u_chk (.*);

/* bench/dbsp_dram_model.sv */
// dram side model: holds the wait pin low after each new column address
`timescale 1ns/1ps
module dbsp_dram_model (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// dram pins
	input wire logic        row_strobe_n,
	input wire logic [15:0] dram_addr,
	output logic            wait_n,
	// waits per new column
	input wire logic [3:0]  nwait
);
	logic [15:0] last, next_last;
	logic [3:0]  cnt, next_cnt;
	logic        hit;

	always_comb begin
		hit = !row_strobe_n && dram_addr != last && nwait != 4'h0;
		next_last = dram_addr;
		next_cnt = hit ? nwait - 4'h1 : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
		wait_n = !(hit || cnt != 4'h0);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last <= 16'h0000;
			cnt <= 4'h0;
		end else begin
			last <= next_last;
			cnt <= next_cnt;
		end
	end
endmodule

/* bench/test_dbsp_top.sv */
// self-checking bench for the dram strobe sequencer
`timescale 1ns/1ps
module test_dbsp_top
	import dbsp_pkg::*;
;
	logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic              acc_req, acc_write, acc_dma, acc_dma_single;
	logic              acc_bus8, acc_lane_hi, acc_lane_lo, acc_done;
	logic              other_area_active, refresh_req, refresh_done;
	logic              wait_n, row_n, cuh, cul, wuh, wul, duty;
	logic [1:0]        htrans;
	logic [31:0]       haddr, hwdata, hrdata, rd;
	logic [ADDR_W-1:0] acc_row, acc_col, dram_addr;
	logic [4:0]        seen;
	logic [3:0]        nwait;
	int                n_mismatch, n_tests, n;
	localparam logic [5:0] RD = 6'h03, WR = 6'h23, WU = 6'h22;

	always #12.5 hclk = !hclk;

	dbsp_top dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.acc_req, .acc_row, .acc_col, .acc_write, .acc_dma, .acc_dma_single,
		.acc_bus8, .acc_lane_hi, .acc_lane_lo, .acc_done, .other_area_active,
		.refresh_req, .refresh_done, .wait_n, .row_strobe_n(row_n),
		.column_strobe_upper_byte_n(cuh), .column_strobe_lower_byte_n(cul),
		.write_strobe_upper_byte_n(wuh), .write_strobe_lower_byte_n(wul),
		.dram_addr, .column_strobe_short_duty(duty)
	);
	dbsp_dram_model u_dram (.hclk, .hresetn, .row_strobe_n(row_n),
		.dram_addr, .wait_n, .nwait);

	// --------
	// tasks
	// --------
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report();
		if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic hwait();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_mismatch++;
			final_report();
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rd = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic cfg(input logic [31:0] c, p);
		bus(OFS_DRAM_CONTROL_REG, 1'b1, c);
		bus(OFS_WAIT_CONTROL_REG, 1'b1, p);
	endtask

	// waits for acc_done, or refresh_done when rf is set
	task automatic run(input logic rf);
		n = 0;
		seen = 5'h00;
		do begin
			@(posedge hclk);
			#1;
			n++;
			seen |= {duty, ~{cuh, cul, wuh, wul}};
		end while ((rf ? refresh_done : acc_done) !== 1'b1 && n < 40);
		acc_req <= 1'b0;
		refresh_req <= 1'b0;
		if (n >= 40) begin
			n_mismatch++;
			final_report();
		end
	endtask

	task automatic acc(input logic [5:0] f, input int en,
		input logic [4:0] em);
		@(posedge hclk);
		{acc_write, acc_dma, acc_dma_single, acc_bus8, acc_lane_hi,
			acc_lane_lo} <= f;
		acc_col <= acc_col + 16'h0001;
		acc_req <= 1'b1;
		run(1'b0);
		chk("latency", n, en);
		chk("strobes", seen, em);
	endtask

	task automatic other();
		@(posedge hclk);
		other_area_active <= 1'b1;
		repeat (3) @(posedge hclk);
		other_area_active <= 1'b0;
	endtask

	// --------
	// sequence
	// --------
	initial begin
		hclk = 1'b0;
		{hresetn, hsel, hwrite, acc_req, other_area_active} = 5'h00;
		{refresh_req, htrans, haddr, hwdata, acc_col, nwait} = 0;
		{acc_write, acc_dma, acc_dma_single, acc_bus8, acc_lane_hi,
			acc_lane_lo} = RD;
		acc_row = 16'h0123;
		n_mismatch = 0;
		n_tests = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		bus(OFS_DRAM_CONTROL_REG, 1'b0, 0);
		chk("ctrl reset", rd, {27'h0, CTRL_RESET});
		bus(OFS_WAIT_CONTROL_REG, 1'b0, 0);
		chk("pitch reset", rd, {28'h0, PITCH_RESET});
		bus(8'h0C, 1'b1, 32'hFFFFFFFF);
		bus(8'h0C, 1'b0, 0);
		chk("unmapped", rd, 32'h00000000);
		bus(OFS_DRAM_CONTROL_REG, 1'b1, 32'hFFFFFFFF);
		bus(OFS_DRAM_CONTROL_REG, 1'b0, 0);
		chk("ctrl bits", rd, 32'h0000001F);
		cfg(32'h00, 32'h0);
		acc(RD, 4, 5'h0C);
		acc(RD, 4, 5'h0C);
		cfg(32'h02, 32'h0);
		acc(RD, 4, 5'h0C);
		acc(RD, 2, 5'h0C);
		acc(WR, 3, 5'h0D);
		acc(WU, 3, 5'h09);
		acc(6'h13, 2, 5'h0C);
		acc(6'h3B, 3, 5'h0D);
		nwait <= 4'h2;
		acc(RD, 2, 5'h0C);
		cfg(32'h03, 32'h0);
		acc(WU, 3, 5'h06);
		acc(6'h25, 3, 5'h05);
		nwait <= 4'h1;
		for (int b = 0; b < 4; b++) begin
			cfg(32'h03, 32'h1 << b);
			for (int t = 0; t < 4; t++) begin
				acc({t[0], t[1], 4'h3}, (t == b) ? 4 : 2 + t[0],
					t[0] ? 5'h07 : 5'h04);
			end
		end
		cfg(32'h02, 32'hF);
		nwait <= 4'h3;
		acc(RD, 6, 5'h0C);
		nwait <= 4'h0;
		acc(RD, 3, 5'h0C);
		cfg(32'h12, 32'h0);
		acc_row <= 16'h0456;
		acc(RD, 5, 5'h0C);
		cfg(32'h0A, 32'h0);
		acc(RD, 2, 5'h1C);
		cfg(32'h02, 32'h0);
		other();
		acc(RD, 4, 5'h0C);
		cfg(32'h06, 32'h0);
		other();
		#1;
		chk("row held", row_n, 0);
		acc(RD, 2, 5'h0C);
		@(posedge hclk);
		refresh_req <= 1'b1;
		run(1'b1);
		chk("refresh", n, 2);
		acc(RD, 4, 5'h0C);
		final_report();
	end
endmodule
